// ---- core/apll_config_registers.v ----
// Configuration registers and control decode for the analog PLL
//
// What this block does
// - Divider B runs only with PLL enabled, its enable set, bypass clear.
// - Bypass set routes bypass path through output mux; clear routes divider.
// - Divider B codes 0-7 divide 4 to 7.5 by halves, 8-15 divide 8-15.
// - Divider A uses the same sixteen-code ratio decoding.
// - Switch mode: selected pin low uses primary select, high uses alternate.
// - Alternate select ignored when switch mode is off.
// - Codes 0-3 pick crystal (or doubled pin), inputs one, two, three.
// - Alternate codes 4 to 7 are unused.
// - Primary 6 and 7 feed oscillator; 6 sends crystal to bypass, 7 nothing.
// - Primary 4 and 5 feed oscillator; 4 sends input one to bypass, 5 nothing.
// - Each edge of decrement control steps phase earlier once.
// - Decrement source: 0 register bit, 1-4 pins 0-3, 5-7 unused.
// - Each edge of increment control steps phase later once.
// - Increment source: 0 register bit, 1-4 pins 0-3, 5-7 unused.
// - Feedback divider is 42 bits: 9 integer, 33 fractional bits.
// - Feedback divider bytes little-endian, bits 7:0 at 106h to 39:32 at 10Ah.
// - Bits 41:40 sit in low two bits at 10Bh; upper six unused.
`include "apll_config_defs.vh"

module apll_config_registers
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Avalon-MM slave
  input wire [11:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // General-purpose pins
  input wire [3:0] gpio_pin,
  // Divider controls
  output reg hs_div2_run,
  output reg hs_div2_bypass_route,
  output reg [4:0] div_a_half_ratio,
  output reg [4:0] div_b_half_ratio,
  // Reference mux controls
  output reg [2:0] pll_ref_source,
  output reg [2:0] bypass_ref_source,
  output reg xtal_doubler_on,
  // Phase steps
  output wire phase_inc_step,
  output wire phase_dec_step,
  // Feedback divider
  output reg [41:0] feedback_divider_value
);

  // Software-visible registers
  reg [7:0] hs_divider_b_enable_bypass;
  reg [7:0] hs_divider_ratios;
  reg [7:0] reference_mux_select;
  reg [7:0] phase_step_control;
  reg [7:0] loose_control;
  reg [7:0] feedback_divider_byte0;
  reg [7:0] feedback_divider_byte1;
  reg [7:0] feedback_divider_byte2;
  reg [7:0] feedback_divider_byte3;
  reg [7:0] feedback_divider_byte4;
  reg [1:0] feedback_divider_top;

  // Pin synchronisers
  reg [3:0] gpio_meta;
  reg [3:0] gpio_sync;

  // Decode results
  reg [7:0] next_readdata;
  reg [2:0] effective_code;
  reg alt_active;
  reg [5:0] ref_pair;
  wire [9:0] word_index;
  wire write_now;
  wire pll_enable;
  wire [1:0] switch_pin_select;
  wire ext_ref_switch_mode;
  wire hs_div2_enable;
  wire hs_div2_bypass;

  assign word_index = address[11:2];
  assign write_now = write && !waitrequest && byteenable[0];
  assign pll_enable = loose_control[`BIT_PLL_ENABLE];
  assign switch_pin_select = loose_control[`MSB_SWITCH_PIN:`LSB_SWITCH_PIN];
  assign ext_ref_switch_mode = reference_mux_select[`BIT_EXT_SWITCH_MODE];
  assign hs_div2_enable = hs_divider_b_enable_bypass[`BIT_HS_DIV2_ENABLE];
  assign hs_div2_bypass = hs_divider_b_enable_bypass[`BIT_HS_DIV2_BYPASS];

  // Ratio in half steps: 8..15 for codes 0-7, 16..30 for codes 8-15
  function [4:0] half_ratio;
    input [3:0] code;
    begin
      if (code[3])
        half_ratio = {code, 1'b0};
      else
        half_ratio = {2'b01, code[2:0]};
    end
  endfunction

  // Returns {pll source, bypass source} for a selection code
  function [5:0] ref_decode;
    input [2:0] code;
    input is_alternate;
    begin
      case (code)
        `REF_XTAL:
          ref_decode = {`SRC_XTAL, `SRC_XTAL};
        `REF_IC1:
          ref_decode = {`SRC_IC1, `SRC_IC1};
        `REF_IC2:
          ref_decode = {`SRC_IC2, `SRC_IC2};
        `REF_IC3:
          ref_decode = {`SRC_IC3, `SRC_IC3};
        `REF_NCO_BYP_IC1:
          ref_decode = {`SRC_NCO, `SRC_IC1};
        `REF_NCO_NO_BYP_B:
          ref_decode = {`SRC_NCO, `SRC_NONE};
        `REF_NCO_BYP_XTAL:
          ref_decode = {`SRC_NCO, `SRC_XTAL};
        default:
          ref_decode = {`SRC_NCO, `SRC_NONE};
      endcase
      if (is_alternate && code[2])
        ref_decode = {`SRC_NONE, `SRC_NONE};
    end
  endfunction

  // Two flip-flops on every pin
  always @(posedge clk)
  begin
    if (reset)
    begin
      gpio_meta <= 4'h0;
      gpio_sync <= 4'h0;
    end
    else
    begin
      gpio_meta <= gpio_pin;
      gpio_sync <= gpio_meta;
    end
  end

  // Reference selection
  always @*
  begin
    alt_active = ext_ref_switch_mode && gpio_sync[switch_pin_select];
    if (alt_active)
      effective_code = reference_mux_select[`MSB_ALT_SEL:`LSB_ALT_SEL];
    else
      effective_code = reference_mux_select[`MSB_PRI_SEL:`LSB_PRI_SEL];
    ref_pair = ref_decode(effective_code, alt_active);
  end

  // Register read mux
  always @*
  begin
    next_readdata = 8'h00;
    if (word_index == `IDX_HS_DIV_B_ENABLE_BYPASS)
      next_readdata = hs_divider_b_enable_bypass;
    else if (word_index == `IDX_HS_DIVIDER_RATIOS)
      next_readdata = hs_divider_ratios;
    else if (word_index == `IDX_REFERENCE_MUX_SELECT)
      next_readdata = reference_mux_select;
    else if (word_index == `IDX_PHASE_STEP_CONTROL)
      next_readdata = phase_step_control;
    else if (word_index == `IDX_LOOSE_CONTROL)
      next_readdata = loose_control;
    else if (word_index == `IDX_BLOCK_STATUS)
      next_readdata = {gpio_sync, hs_div2_run, pll_ref_source};
    else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE0)
      next_readdata = feedback_divider_byte0;
    else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE1)
      next_readdata = feedback_divider_byte1;
    else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE2)
      next_readdata = feedback_divider_byte2;
    else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE3)
      next_readdata = feedback_divider_byte3;
    else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE4)
      next_readdata = feedback_divider_byte4;
    else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE5)
      next_readdata = {6'h00, feedback_divider_top};
  end

  // Bus handshake: one wait cycle, then the request completes
  always @(posedge clk)
  begin
    if (reset)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else if ((read || write) && waitrequest)
    begin
      waitrequest <= 1'b0;
      readdata <= {24'h000000, next_readdata};
    end
    else
    begin
      waitrequest <= 1'b1;
    end
  end

  // Control register writes; reserved bits stay zero
  always @(posedge clk)
  begin
    if (reset)
    begin
      hs_divider_b_enable_bypass <= `RST_BYTE;
      hs_divider_ratios <= `RST_BYTE;
      reference_mux_select <= `RST_BYTE;
      phase_step_control <= `RST_BYTE;
      loose_control <= `RST_BYTE;
    end
    else if (write_now)
    begin
      if (word_index == `IDX_HS_DIV_B_ENABLE_BYPASS)
        hs_divider_b_enable_bypass <= {5'h00, writedata[2:1], 1'b0};
      else if (word_index == `IDX_HS_DIVIDER_RATIOS)
        hs_divider_ratios <= writedata[7:0];
      else if (word_index == `IDX_REFERENCE_MUX_SELECT)
        reference_mux_select <= {1'b0, writedata[6:0]};
      else if (word_index == `IDX_PHASE_STEP_CONTROL)
        phase_step_control <= writedata[7:0];
      else if (word_index == `IDX_LOOSE_CONTROL)
        loose_control <= {3'h0, writedata[4:0]};
    end
  end

  // Feedback divider byte writes
  always @(posedge clk)
  begin
    if (reset)
    begin
      feedback_divider_byte0 <= `RST_BYTE;
      feedback_divider_byte1 <= `RST_BYTE;
      feedback_divider_byte2 <= `RST_BYTE;
      feedback_divider_byte3 <= `RST_BYTE;
      feedback_divider_byte4 <= `RST_BYTE;
      feedback_divider_top <= `RST_TOP_BITS;
    end
    else if (write_now)
    begin
      if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE0)
        feedback_divider_byte0 <= writedata[7:0];
      else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE1)
        feedback_divider_byte1 <= writedata[7:0];
      else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE2)
        feedback_divider_byte2 <= writedata[7:0];
      else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE3)
        feedback_divider_byte3 <= writedata[7:0];
      else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE4)
        feedback_divider_byte4 <= writedata[7:0];
      else if (word_index == `IDX_FEEDBACK_DIVIDER_BYTE5)
        feedback_divider_top <= writedata[1:0];
    end
  end

  // Divider B run and bypass route
  always @(posedge clk)
  begin
    if (reset)
    begin
      hs_div2_run <= 1'b0;
      hs_div2_bypass_route <= 1'b0;
    end
    else
    begin
      hs_div2_run <= pll_enable && hs_div2_enable && !hs_div2_bypass;
      hs_div2_bypass_route <= hs_div2_bypass;
    end
  end

  // Divider ratios in half steps
  always @(posedge clk)
  begin
    if (reset)
    begin
      div_a_half_ratio <= `RST_HALF_RATIO;
      div_b_half_ratio <= `RST_HALF_RATIO;
    end
    else
    begin
      div_b_half_ratio <= half_ratio(hs_divider_ratios[`MSB_DIV_B:`LSB_DIV_B]);
      div_a_half_ratio <= half_ratio(hs_divider_ratios[`MSB_DIV_A:`LSB_DIV_A]);
    end
  end

  // Reference mux outputs
  always @(posedge clk)
  begin
    if (reset)
    begin
      pll_ref_source <= `SRC_NONE;
      bypass_ref_source <= `SRC_NONE;
      xtal_doubler_on <= 1'b0;
    end
    else
    begin
      pll_ref_source <= ref_pair[5:3];
      bypass_ref_source <= ref_pair[2:0];
      xtal_doubler_on <= loose_control[`BIT_XTAL_DOUBLER];
    end
  end

  // Feedback divider word
  always @(posedge clk)
  begin
    if (reset)
    begin
      feedback_divider_value <= `RST_FEEDBACK_VALUE;
    end
    else
    begin
      feedback_divider_value <= {feedback_divider_top, feedback_divider_byte4, feedback_divider_byte3,
        feedback_divider_byte2, feedback_divider_byte1, feedback_divider_byte0};
    end
  end

  // Phase decrement path
  phase_step_source decrement_path
  (
    .clk(clk),
    .reset(reset),
    .source_select(phase_step_control[`MSB_DEC_SRC:`LSB_DEC_SRC]),
    .control_bit(phase_step_control[`BIT_PHASE_DEC]),
    .gpio_level(gpio_sync),
    .step(phase_dec_step)
  );

  // Phase increment path
  phase_step_source increment_path
  (
    .clk(clk),
    .reset(reset),
    .source_select(phase_step_control[`MSB_INC_SRC:`LSB_INC_SRC]),
    .control_bit(phase_step_control[`BIT_PHASE_INC]),
    .gpio_level(gpio_sync),
    .step(phase_inc_step)
  );

endmodule

// ---- core/apll_config_defs.vh ----
// Register indices, field positions, reset values and source codes for the PLL configuration block
`ifndef APLL_CONFIG_DEFS_VH
`define APLL_CONFIG_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_HS_DIV_B_ENABLE_BYPASS 10'h100
`define IDX_HS_DIVIDER_RATIOS 10'h101
`define IDX_REFERENCE_MUX_SELECT 10'h102
`define IDX_PHASE_STEP_CONTROL 10'h103
`define IDX_LOOSE_CONTROL 10'h104
`define IDX_BLOCK_STATUS 10'h105
`define IDX_FEEDBACK_DIVIDER_BYTE0 10'h106
`define IDX_FEEDBACK_DIVIDER_BYTE1 10'h107
`define IDX_FEEDBACK_DIVIDER_BYTE2 10'h108
`define IDX_FEEDBACK_DIVIDER_BYTE3 10'h109
`define IDX_FEEDBACK_DIVIDER_BYTE4 10'h10A
`define IDX_FEEDBACK_DIVIDER_BYTE5 10'h10B

// Reset values
`define RST_BYTE 8'h00
`define RST_TOP_BITS 2'h0
`define RST_HALF_RATIO 5'h08
`define RST_FEEDBACK_VALUE 42'h00000000000

// Enable and bypass register fields
`define BIT_HS_DIV2_ENABLE 2
`define BIT_HS_DIV2_BYPASS 1

// Divider ratio fields
`define MSB_DIV_B 7
`define LSB_DIV_B 4
`define MSB_DIV_A 3
`define LSB_DIV_A 0

// Reference mux fields
`define BIT_EXT_SWITCH_MODE 6
`define MSB_ALT_SEL 5
`define LSB_ALT_SEL 3
`define MSB_PRI_SEL 2
`define LSB_PRI_SEL 0

// Phase step fields
`define BIT_PHASE_DEC 7
`define MSB_DEC_SRC 6
`define LSB_DEC_SRC 4
`define BIT_PHASE_INC 3
`define MSB_INC_SRC 2
`define LSB_INC_SRC 0

// Loose control fields
`define BIT_PLL_ENABLE 0
`define MSB_SWITCH_PIN 2
`define LSB_SWITCH_PIN 1
`define BIT_XTAL_DOUBLER 3
`define BIT_OSC_FROM_ONE 4

// Reference selection codes
`define REF_XTAL 3'h0
`define REF_IC1 3'h1
`define REF_IC2 3'h2
`define REF_IC3 3'h3
`define REF_NCO_BYP_IC1 3'h4
`define REF_NCO_NO_BYP_B 3'h5
`define REF_NCO_BYP_XTAL 3'h6
`define REF_NCO_NO_BYP 3'h7

// Source codes driven onto the mux outputs
`define SRC_NONE 3'h0
`define SRC_XTAL 3'h1
`define SRC_IC1 3'h2
`define SRC_IC2 3'h3
`define SRC_IC3 3'h4
`define SRC_NCO 3'h5

// Phase step source codes
`define STEP_SRC_BIT 3'h0
`define STEP_SRC_GPIO0 3'h1
`define STEP_SRC_GPIO3 3'h4

`endif

// ---- core/phase_step_source.v ----
// Selects one phase step control signal and turns each of its edges into a step pulse
`include "apll_config_defs.vh"

module phase_step_source
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Selection and candidate signals
  input wire [2:0] source_select,
  input wire control_bit,
  input wire [3:0] gpio_level,
  // Step pulse
  output reg step
);

  reg chosen;
  reg chosen_valid;
  reg prev_level;
  reg [2:0] prev_select;
  wire [2:0] gpio_index;

  assign gpio_index = source_select - `STEP_SRC_GPIO0;

  // Source multiplexer
  always @*
  begin
    chosen = 1'b0;
    chosen_valid = 1'b0;
    if (source_select == `STEP_SRC_BIT)
    begin
      chosen = control_bit;
      chosen_valid = 1'b1;
    end
    else if (source_select <= `STEP_SRC_GPIO3)
    begin
      chosen = gpio_level[gpio_index[1:0]];
      chosen_valid = 1'b1;
    end
  end

  // Both edges step once; a source change gives no step
  always @(posedge clk)
  begin
    if (reset)
    begin
      prev_level <= 1'b0;
      prev_select <= `STEP_SRC_BIT;
      step <= 1'b0;
    end
    else
    begin
      prev_level <= chosen;
      prev_select <= source_select;
      step <= chosen_valid && (source_select == prev_select) && (chosen != prev_level);
    end
  end

endmodule

// ---- bench/apll_config_registers_props.sv ----
// Port assertions for the PLL configuration registers
module apll_config_registers_props
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Bus
  input wire [11:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Controls
  input wire hs_div2_run,
  input wire hs_div2_bypass_route,
  input wire [4:0] div_a_half_ratio,
  input wire [4:0] div_b_half_ratio,
  input wire [2:0] pll_ref_source,
  input wire [2:0] bypass_ref_source,
  input wire [41:0] feedback_divider_value
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire ack = write && !waitrequest && byteenable[0];
  wire [9:0] idx = address[11:2];
  wire [7:0] wd = writedata[7:0];
  function automatic [4:0] half(input [3:0] c);
    half = c[3] ? {c, 1'b0} : {1'b0, c} + 5'h08;
  endfunction
  run_gate_a: assert property (ack && idx == 10'h100 |=> ##1 hs_div2_run |-> $past(wd[2], 2) && !$past(wd[1], 2))
    else $error("divider b runs while off");
  run_excl_a: assert property (hs_div2_run |-> !hs_div2_bypass_route)
    else $error("divider b runs while bypassed");
  bypass_route_a: assert property (ack && idx == 10'h100 |=> ##1 hs_div2_bypass_route == $past(wd[1], 2))
    else $error("bypass route wrong");
  ratio_b_a: assert property (ack && idx == 10'h101 |=> ##1 div_b_half_ratio == half($past(wd[7:4], 2)))
    else $error("divider b ratio wrong");
  ratio_a_a: assert property (ack && idx == 10'h101 |=> ##1 div_a_half_ratio == half($past(wd[3:0], 2)))
    else $error("divider a ratio wrong");
  ref_low_a: assert property (ack && idx == 10'h102 && !wd[6] && !wd[2] |=> ##1
    pll_ref_source == {1'b0, $past(wd[1:0], 2)} + 3'h1)
    else $error("reference source wrong");
  ref_osc_a: assert property (ack && idx == 10'h102 && !wd[6] && wd[2] |=> ##1 pll_ref_source == 3'h5 &&
    bypass_ref_source == ($past(wd[0], 2) ? 3'h0 : $past(wd[1], 2) ? 3'h1 : 3'h2))
    else $error("oscillator routing wrong");
  fb_low_a: assert property (ack && idx == 10'h106 |=> ##1 feedback_divider_value[7:0] == $past(wd, 2))
    else $error("feedback low byte wrong");
  fb_top_a: assert property (ack && idx == 10'h10B |=> ##1 feedback_divider_value[41:40] == $past(wd[1:0], 2))
    else $error("feedback top bits wrong");
  top_read_a: assert property (read && !waitrequest && idx == 10'h10B |-> readdata[7:2] == 6'h00)
    else $error("unused top bits read set");
endmodule

bind apll_config_registers apll_config_registers_props chk (.*);

// ---- bench/tb_apll_config_registers.sv ----
// Self-checking bench for the PLL configuration registers
module tb_apll_config_registers;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, read, write;
  logic [11:0] address;
  logic [31:0] writedata;
  logic [3:0] byteenable, gpio_pin;
  wire [31:0] readdata;
  wire waitrequest, hs_div2_run, hs_div2_bypass_route, xtal_doubler_on, phase_inc_step, phase_dec_step;
  wire [4:0] div_a_half_ratio, div_b_half_ratio;
  wire [2:0] pll_ref_source, bypass_ref_source;
  wire [41:0] feedback_divider_value;
  int n_mismatch, checks, n_inc, n_dec, base_inc, base_dec;
  logic [7:0] q;
  logic [41:0] fb;

  apll_config_registers dut (.*);

  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // Step pulse counters
  always @(posedge clk)
  begin
    n_inc <= n_inc + phase_inc_step;
    n_dec <= n_dec + phase_dec_step;
  end

  function automatic logic [4:0] half(input int c);
    return c < 8 ? c + 8 : 2 * c;
  endfunction

  task check(input logic [41:0] seen, input logic [41:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One bus transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] be);
    int n;
    begin
      @(posedge clk);
      address <= {idx, 2'b00};
      read <= !w;
      write <= w;
      writedata <= {24'($urandom), d};
      byteenable <= be;
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (waitrequest !== 1'b0 && n < 10);
      q = readdata[7:0];
      read <= 0;
      write <= 0;
      if (n >= 10)
      begin
        n_mismatch++;
        results;
      end
    end
  endtask

  task settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  initial
  begin
    void'($urandom(32'h800db368));
    reset = 1;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    byteenable = 0;
    gpio_pin = 0;
    repeat (2) @(posedge clk);
    reset <= 0;
    settle(1);
    check(div_a_half_ratio, 8);
    check(div_b_half_ratio, 8);
    for (int i = 0; i < 11; i++)
    begin
      bus(0, 10'h100 + i, 0, 4'hF);
      if (i != 4 && i != 5)
        check(q, 0);
    end
    // All ratio codes in both fields
    for (int c = 0; c < 16; c++)
    begin
      bus(1, 10'h101, {4'(c), 4'(15 - c)}, 4'hF);
      settle(1);
      check(div_b_half_ratio, half(c));
      check(div_a_half_ratio, half(15 - c));
    end
    fb = 42'({$urandom, $urandom});
    fb[33] = 1;
    for (int i = 0; i < 6; i++)
      bus(1, 10'h106 + i, 8'(fb >> (8 * i)), 4'hF);
    settle(1);
    check(feedback_divider_value, fb);
    bus(1, 10'h10B, 8'hFF, 4'hF);
    bus(0, 10'h10B, 0, 4'hF);
    check(q, 3);
    bus(0, 10'h108, 0, 4'hF);
    check(q, fb[23:16]);
    // Masked write and unmapped place
    bus(1, 10'h106, ~fb[7:0], 4'hE);
    bus(1, 10'h3FF, 8'hFF, 4'hF);
    bus(0, 10'h3FF, 0, 4'hF);
    check(q, 0);
    bus(0, 10'h106, 0, 4'hF);
    check(q, fb[7:0]);
    for (int i = 0; i < 8; i++)
    begin
      bus(1, 10'h104, {4'h0, i[0], 2'h0, i[2]}, 4'hF);
      bus(1, 10'h100, {5'h0, 2'(i), 1'b0}, 4'hF);
      settle(1);
      check(hs_div2_run, i == 6);
      check(hs_div2_bypass_route, i[0]);
      check(xtal_doubler_on, i[0]);
    end
    bus(1, 10'h100, 0, 4'hF);
    for (int c = 0; c < 8; c++)
    begin
      bus(1, 10'h102, {2'b00, 3'($urandom), 3'(c)}, 4'hF);
      settle(1);
      check(pll_ref_source, c < 4 ? c + 1 : 5);
      if (c > 3)
        check(bypass_ref_source, c == 4 ? 2 : c == 6 ? 1 : 0);
    end
    // Pin-driven switching
    for (int k = 0; k < 8; k++)
    begin
      int a, pr;
      a = $urandom % 8;
      pr = $urandom % 4;
      @(posedge clk);
      gpio_pin <= 4'($urandom);
      bus(1, 10'h104, 8'((k % 4) << 1), 4'hF);
      bus(1, 10'h102, {2'b01, 3'(a), 3'(pr)}, 4'hF);
      settle(4);
      check(pll_ref_source, !gpio_pin[k % 4] ? pr + 1 : a < 4 ? a + 1 : 0);
    end
    bus(1, 10'h102, 0, 4'hF);
    // Phase step sources, both edges
    for (int s = 0; s < 8; s++)
    begin
      bus(1, 10'h103, {1'b0, 3'(s), 1'b0, 3'(s)}, 4'hF);
      settle(5);
      base_inc = n_inc;
      base_dec = n_dec;
      for (int t = 0; t < 2; t++)
      begin
        @(posedge clk);
        gpio_pin <= ~gpio_pin;
        bus(1, 10'h103, {1'(!t), 3'(s), 1'(!t), 3'(s)}, 4'hF);
        settle(5);
      end
      check(n_inc - base_inc, s < 5 ? 2 : 0);
      check(n_dec - base_dec, s < 5 ? 2 : 0);
    end
    // Reset in mid-run
    @(posedge clk);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    bus(0, 10'h10A, 0, 4'hF);
    check(q, 0);
    settle(1);
    check(feedback_divider_value, 0);
    results;
  end
endmodule
